// >>> logic/rate_switch_reconfig_sequencer.sv
// Module: arbiter and state machine that switch channels between 1G and 10G
// Functional notes
// - With speed detection on, accept each channel's detector rate-change request.
// - Simultaneous requests are prioritised; only one is serviced at a time.
// - Arbiter picks one channel and raises its grant handshake.
// - Granted channel number and rate go to the state machine.
// - No new grant until the state machine reports done.
// - Start only when controller idle and both reset-controller readies high.
// - Program the reconfiguration controller with the logical channel number.
// - Select streaming mode and stream the image for the requested rate.
// - Wait for busy to rise then fall; the fall marks completion.
// - Pulse the channel's digital resets, then wait for its link ready.
// - Finally drop the grant so another request may be served.
// - One image store per configuration: one 1G, one 10G.
// - Only coding-sublayer settings change; medium attachment settings stay.
// - Images omit transmit equalisation words: depth 164, not 168.
`timescale 1ns/10ps
module rate_switch_reconfig_sequencer
  import rate_switch_pkg::*;
#(
  parameter int NUM_CHAN  = NUM_CHAN_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter logic [IMAGE_W*IMAGE_DEPTH-1:0] IMAGE_LOW  = '0,
  parameter logic [IMAGE_W*IMAGE_DEPTH-1:0] IMAGE_HIGH = '0
) (
  input  wire logic                CLK,
  input  wire logic                RST,
  input  wire logic                SPEED_DETECT_EN,
  input  wire logic [NUM_CHAN-1:0] DETECT_REQ,
  input  wire logic [NUM_CHAN-1:0] DETECT_LOW_RATE,
  input  wire logic [NUM_CHAN-1:0] MANUAL_REQ,
  input  wire logic [NUM_CHAN-1:0] LOW_RATE_SELECT,
  output logic [NUM_CHAN-1:0]      GRANT,
  input  wire logic                RECONFIG_BUSY,
  input  wire logic                TX_READY,
  input  wire logic                RX_READY,
  input  wire logic [NUM_CHAN-1:0] LINK_READY,
  output logic                     CMD_START,
  output logic [CHAN_W-1:0]        CMD_CHAN,
  output logic                     CMD_STREAM_MODE,
  output logic                     CMD_LOW_RATE,
  output logic                     IMAGE_VALID,
  input  wire logic                IMAGE_READY,
  output logic [IMAGE_W-1:0]       IMAGE_DATA,
  output logic [NUM_CHAN-1:0]      DIGITAL_RESET,
  output logic                     DONE
);

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [3:0] {
    IDLE, WAIT_READY, SET_CHAN, STREAM, WAIT_RISE, WAIT_FALL,
    PULSE_RST, WAIT_LINK, RELEASE
  } seq_state_t;

  typedef struct packed {
    seq_state_t            fsm;
    rate_req_t             job;
    logic [NUM_CHAN-1:0]   grant;
    reconfig_cmd_t         cmd;
    logic [IMAGE_AW-1:0]   addr;
    logic                  feeding;
    logic [CNT_W-1:0]      cnt;
    logic [NUM_CHAN-1:0]   dig_rst;
    logic                  done;
    logic [1:0]            busy_s;
    logic [1:0]            txr_s;
    logic [1:0]            rxr_s;
    logic [NUM_CHAN-1:0]   lnk_s1;
    logic [NUM_CHAN-1:0]   lnk_s2;
    logic [NUM_CHAN-1:0]   req_s1;
    logic [NUM_CHAN-1:0]   req_s2;
    logic [NUM_CHAN-1:0]   mode_s1;
    logic [NUM_CHAN-1:0]   mode_s2;
  } seq_t;

  seq_t st;
  seq_t next_st;

  logic                busy;
  logic                sys_ready;
  logic [NUM_CHAN-1:0] req_vec;
  logic [NUM_CHAN-1:0] mode_vec;
  logic                any_req;
  logic [CHAN_W-1:0]   pick;
  logic [IMAGE_W-1:0]  image_word;
  logic                fifo_in_ready;

  // ****************************************************************
  // Request selection
  // ****************************************************************
  assign req_vec  = SPEED_DETECT_EN ? DETECT_REQ : MANUAL_REQ;
  assign mode_vec = SPEED_DETECT_EN ? DETECT_LOW_RATE : LOW_RATE_SELECT;

  // Lowest channel number wins
  function automatic logic [CHAN_W-1:0] lowest_set(input logic [NUM_CHAN-1:0] v);
    lowest_set = '0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest_set = CHAN_W'(i);
      end
    end
  endfunction : lowest_set

  // Word of a packed image, word 0 in the low bits
  function automatic logic [IMAGE_W-1:0] image_at(
    input logic [IMAGE_W*IMAGE_DEPTH-1:0] img,
    input logic [IMAGE_AW-1:0]            a
  );
    image_at = img[a*IMAGE_W +: IMAGE_W];
  endfunction : image_at

  assign any_req   = |st.req_s2;
  assign pick      = lowest_set(st.req_s2);
  assign busy      = st.busy_s[1];
  assign sys_ready = !busy && st.txr_s[1] && st.rxr_s[1];
  // Two stores, one per rate; 164 words each, transmit equalisation left out
  assign image_word = st.job.low_rate_select ? image_at(IMAGE_LOW, st.addr)
                                             : image_at(IMAGE_HIGH, st.addr);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    next_st           = st;
    next_st.busy_s    = {st.busy_s[0], RECONFIG_BUSY};
    next_st.txr_s     = {st.txr_s[0], TX_READY};
    next_st.rxr_s     = {st.rxr_s[0], RX_READY};
    next_st.lnk_s1    = LINK_READY;
    next_st.lnk_s2    = st.lnk_s1;
    next_st.req_s1    = req_vec;
    next_st.req_s2    = st.req_s1;
    next_st.mode_s1   = mode_vec;
    next_st.mode_s2   = st.mode_s1;
    next_st.cmd.start = 1'b0;
    next_st.done      = 1'b0;
    case (st.fsm)
      IDLE: begin
        if (any_req) begin
          next_st.grant               = '0;
          next_st.grant[pick]         = 1'b1;
          next_st.job.chan            = pick;
          next_st.job.low_rate_select = st.mode_s2[pick];
          next_st.fsm                 = WAIT_READY;
        end
      end
      WAIT_READY: begin
        if (sys_ready) begin
          next_st.fsm = SET_CHAN;
        end
      end
      SET_CHAN: begin
        next_st.cmd.chan        = st.job.chan;
        next_st.cmd.stream_mode = 1'b1;
        next_st.addr            = '0;
        next_st.feeding         = 1'b1;
        next_st.fsm             = STREAM;
      end
      STREAM: begin
        // Image holds coding-sublayer words only
        if (fifo_in_ready) begin
          next_st.addr = st.addr + 1'b1;
          if (st.addr == IMAGE_LAST) begin
            next_st.feeding   = 1'b0;
            next_st.cmd.start = 1'b1;
            next_st.fsm       = WAIT_RISE;
          end
        end
      end
      WAIT_RISE: begin
        if (busy) begin
          next_st.fsm = WAIT_FALL;
        end
      end
      WAIT_FALL: begin
        if (!busy) begin
          next_st.cmd.stream_mode     = 1'b0;
          next_st.dig_rst             = '0;
          next_st.dig_rst[st.job.chan] = 1'b1;
          next_st.cnt                 = CNT_W'(RST_PULSE_CYC - 1);
          next_st.fsm                 = PULSE_RST;
        end
      end
      PULSE_RST: begin
        if (st.cnt == CNT_ZERO) begin
          next_st.dig_rst = '0;
          next_st.fsm     = WAIT_LINK;
        end else begin
          next_st.cnt = st.cnt - 1'b1;
        end
      end
      WAIT_LINK: begin
        if (st.lnk_s2[st.job.chan]) begin
          next_st.fsm = RELEASE;
        end
      end
      RELEASE: begin
        next_st.grant = '0;
        next_st.done  = 1'b1;
        next_st.fsm   = IDLE;
      end
      default: begin
        next_st.fsm = IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Image buffer toward the reconfiguration controller
  // ****************************************************************
  image_fifo #(
    .WIDTH (IMAGE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .CLK       (CLK),
    .RST       (RST),
    .in_valid  (st.feeding),
    .in_ready  (fifo_in_ready),
    .in_data   (image_word),
    .out_valid (IMAGE_VALID),
    .out_ready (IMAGE_READY),
    .out_data  (IMAGE_DATA)
  );

  assign GRANT           = st.grant;
  assign CMD_START       = st.cmd.start;
  assign CMD_CHAN        = st.cmd.chan;
  assign CMD_STREAM_MODE = st.cmd.stream_mode;
  assign CMD_LOW_RATE    = st.job.low_rate_select;
  assign DIGITAL_RESET   = st.dig_rst;
  assign DONE            = st.done;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_ONE_GRANT: assert property (@(posedge CLK) disable iff (RST)
    $onehot0(st.grant))
    else $error("More than one grant");

  AST_GRANT_LOWEST: assert property (@(posedge CLK) disable iff (RST)
    (st.fsm == IDLE && any_req) |=> GRANT[$past(pick)])
    else $error("Grant not to lowest requestor");

  AST_NO_REGRANT: assert property (@(posedge CLK) disable iff (RST)
    (st.fsm != IDLE && st.fsm != RELEASE) |=> $stable(st.grant))
    else $error("Grant changed during service");

  AST_GRANT_FROM_IDLE: assert property (@(posedge CLK) disable iff (RST)
    $rose(|GRANT) |-> $past(st.fsm) == IDLE)
    else $error("Grant raised while busy");

  AST_GRANT_HAS_REQ: assert property (@(posedge CLK) disable iff (RST)
    $rose(|GRANT) |-> ($past(st.req_s2) & GRANT) != '0)
    else $error("Grant without a request");

  AST_DETECT_PATH: assert property (@(posedge CLK) disable iff (RST)
    SPEED_DETECT_EN |=> st.req_s1 == $past(DETECT_REQ))
    else $error("Detector request not taken");

  AST_MANUAL_PATH: assert property (@(posedge CLK) disable iff (RST)
    !SPEED_DETECT_EN |=> st.mode_s1 == $past(LOW_RATE_SELECT))
    else $error("Manual rate not taken");

  AST_JOB_CHAN: assert property (@(posedge CLK) disable iff (RST)
    $rose(|GRANT) |-> GRANT[st.job.chan])
    else $error("Job channel differs from grant");

  AST_JOB_RATE: assert property (@(posedge CLK) disable iff (RST)
    $rose(|GRANT) |-> CMD_LOW_RATE == $past(st.mode_s2[pick]))
    else $error("Job rate differs from request");

  AST_START_READY: assert property (@(posedge CLK) disable iff (RST)
    (st.fsm == WAIT_READY && !sys_ready) |=> st.fsm == WAIT_READY)
    else $error("Started while not ready");

  AST_READY_SEEN: assert property (@(posedge CLK) disable iff (RST)
    $rose(CMD_STREAM_MODE) |-> $past(sys_ready, 2))
    else $error("Streaming without ready");

  AST_CHAN_PROG: assert property (@(posedge CLK) disable iff (RST)
    $rose(CMD_STREAM_MODE) |-> CMD_CHAN == st.job.chan)
    else $error("Wrong channel programmed");

  AST_CHAN_HOLD: assert property (@(posedge CLK) disable iff (RST)
    CMD_STREAM_MODE |-> CMD_CHAN == st.job.chan)
    else $error("Channel changed while streaming");

  AST_START_PULSE: assert property (@(posedge CLK) disable iff (RST)
    CMD_START |=> !CMD_START)
    else $error("Start longer than one cycle");

  AST_START_MODE: assert property (@(posedge CLK) disable iff (RST)
    CMD_START |-> CMD_STREAM_MODE)
    else $error("Start outside streaming mode");

  AST_STREAM_LEN: assert property (@(posedge CLK) disable iff (RST)
    CMD_START |-> $past(st.addr) == IMAGE_LAST)
    else $error("Image length wrong");

  AST_WAIT_RISE: assert property (@(posedge CLK) disable iff (RST)
    (st.fsm == WAIT_RISE && !busy) |=> st.fsm == WAIT_RISE)
    else $error("Left before busy rose");

  AST_WAIT_FALL: assert property (@(posedge CLK) disable iff (RST)
    (st.fsm == WAIT_FALL && busy) |=> st.fsm == WAIT_FALL && !(|DIGITAL_RESET))
    else $error("Left before busy fell");

  AST_FALL_DONE: assert property (@(posedge CLK) disable iff (RST)
    (st.fsm == WAIT_FALL && !busy) |=> DIGITAL_RESET[st.job.chan])
    else $error("Reset not pulsed after completion");

  // Pulse of RST_PULSE_CYC (20) cycles, then low
  AST_RST_WIDTH: assert property (@(posedge CLK) disable iff (RST)
    $rose(|DIGITAL_RESET) |-> (|DIGITAL_RESET)[*8] ##1 (|DIGITAL_RESET)[*8]
      ##1 (|DIGITAL_RESET)[*4] ##1 !(|DIGITAL_RESET))
    else $error("Digital reset width wrong");

  AST_RST_ONEHOT: assert property (@(posedge CLK) disable iff (RST)
    $onehot0(DIGITAL_RESET))
    else $error("Reset on more than one channel");

  AST_LINK_WAIT: assert property (@(posedge CLK) disable iff (RST)
    (st.fsm == WAIT_LINK && !st.lnk_s2[st.job.chan]) |=> st.fsm == WAIT_LINK && GRANT != '0)
    else $error("Released before link ready");

  AST_RELEASE: assert property (@(posedge CLK) disable iff (RST)
    DONE |-> GRANT == '0 && $past(st.fsm) == RELEASE)
    else $error("Grant not dropped at done");

  AST_DONE_PULSE: assert property (@(posedge CLK) disable iff (RST)
    DONE |=> !DONE)
    else $error("Done longer than one cycle");

  AST_GRANT_DROP: assert property (@(posedge CLK) disable iff (RST)
    $fell(|GRANT) |-> DONE)
    else $error("Grant dropped without done");

endmodule : rate_switch_reconfig_sequencer

// >>> logic/rate_switch_pkg.sv
// Package: types and constants for the rate-change reconfiguration sequencer
package rate_switch_pkg;

  localparam int NUM_CHAN_DEF   = 4;
  localparam int CHAN_W         = 2;
  localparam int IMAGE_W        = 16;
  localparam int IMAGE_DEPTH    = 164;
  localparam int IMAGE_DEPTH_RAW = 168;
  localparam int IMAGE_AW       = 8;
  localparam int FIFO_DEPTH_DEF = 8;

  // Digital reset pulse width
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int RST_PULSE_NS    = 100;
  localparam int RST_PULSE_CYC   = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W           = 16;

  localparam logic [IMAGE_AW-1:0] IMAGE_LAST = 8'hA3;
  localparam logic [CNT_W-1:0]    CNT_ZERO   = 16'h0000;

  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic              low_rate_select;
  } rate_req_t;

  typedef struct packed {
    logic               start;
    logic [CHAN_W-1:0]  chan;
    logic               stream_mode;
  } reconfig_cmd_t;

endpackage : rate_switch_pkg

// >>> logic/image_fifo.sv
// Module: parameterised flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module image_fifo
  import rate_switch_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic        push;
  logic        pop;

  assign in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st.cnt != '0);
  assign out_data  = st.mem[st.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr         = wrap_inc(st.wr);
    end
    if (pop) begin
      next_st.rd = wrap_inc(st.rd);
    end
    next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : image_fifo

// >>> sim/reconfig_partner.sv
// Partner model: reconfiguration controller, reset controller and link status
`timescale 1ns/10ps
module reconfig_partner
  import rate_switch_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               cmd_start,
  input  wire logic               image_valid,
  input  wire logic [IMAGE_W-1:0] image_data,
  input  wire logic [3:0]         digital_reset,
  input  wire logic               stall,
  input  wire logic               hold,
  input  wire logic               slow,
  output logic                    image_ready,
  output logic                    reconfig_busy,
  output logic                    tx_ready,
  output logic                    rx_ready,
  output logic [3:0]              link_ready,
  output logic [15:0]             words,
  output logic [15:0]             last_word,
  output logic [15:0]             rst_len,
  output logic [3:0]              rst_mask
);
  int         cnt = 0;
  int         link_wait = 0;
  logic [3:0] prev_rst = '0;

  initial begin
    reconfig_busy = 1'b0;
    link_ready = 4'hF;
    words = '0;
    last_word = '0;
    rst_len = '0;
    rst_mask = '0;
  end

  assign image_ready = !stall;
  assign tx_ready    = !hold;
  assign rx_ready    = !hold;

  // ****************************************
  // One controller for every channel
  // ****************************************
  always begin
    @(posedge clk iff cmd_start === 1'b1);
    repeat (slow ? 9 : 1) @(posedge clk);
    #1 reconfig_busy = 1'b1;
    repeat (slow ? 40 : 3) @(posedge clk);
    while (image_valid) @(posedge clk);
    #1 reconfig_busy = 1'b0;
  end

  always @(posedge clk) begin
    if (image_valid && image_ready) begin
      cnt++;
      last_word = image_data;
    end
    if (|digital_reset) begin
      if (!(|prev_rst)) begin
        words = 16'(cnt);
        cnt = 0;
        rst_len = '0;
        rst_mask = '0;
      end
      rst_len = rst_len + 16'h1;
      rst_mask = rst_mask | digital_reset;
      link_wait = 6;
    end else if (link_wait > 0) begin
      link_wait--;
    end
    prev_rst = digital_reset;
    #1 link_ready = (link_wait > 0) ? ~rst_mask : 4'hF;
  end
endmodule : reconfig_partner

// >>> sim/test_rate_switch_reconfig_sequencer.sv
// Testbench: rate-change sequencer against the reconfiguration partner model
`timescale 1ns/10ps
module test_rate_switch_reconfig_sequencer
  import rate_switch_pkg::*;
;
  localparam logic [15:0] W_LOW  = 16'h1A1A;
  localparam logic [15:0] W_HIGH = 16'h2B2B;
  // Last word of each image differs from the rest
  localparam logic [15:0] E_LOW  = 16'h1AE5;
  localparam logic [15:0] E_HIGH = 16'h2BD4;
  typedef struct {int chan; logic rate;} note_t;
  logic CLK = 0, RST = 1, SPEED_DETECT_EN = 0, stall = 0, hold = 0, slow = 0;
  logic [3:0] DETECT_REQ = '0, DETECT_LOW_RATE = '0, MANUAL_REQ = '0, LOW_RATE_SELECT = '0;
  logic [3:0] drive = '0, want = '0, rate = '0, prev_grant = '0, GRANT, DIGITAL_RESET;
  logic [3:0] LINK_READY, rst_mask;
  logic RECONFIG_BUSY, TX_READY, RX_READY, CMD_START, CMD_STREAM_MODE, CMD_LOW_RATE;
  logic IMAGE_VALID, IMAGE_READY, DONE, m_en = 0, m_stall = 0, m_hold = 0;
  logic [1:0] CMD_CHAN;
  logic [15:0] IMAGE_DATA, words, last_word, rst_len;
  logic [31:0] seed = 32'hDDD2959B;
  int n_errors = 0, comparisons = 0, jobs = 0;
  note_t q[$];
  note_t cur;

  always #2.5 CLK = ~CLK;

  rate_switch_reconfig_sequencer #(.IMAGE_LOW({E_LOW, {IMAGE_DEPTH-1{W_LOW}}}),
    .IMAGE_HIGH({E_HIGH, {IMAGE_DEPTH-1{W_HIGH}}})) DUT (.CLK, .RST, .SPEED_DETECT_EN,
    .DETECT_REQ,
    .DETECT_LOW_RATE, .MANUAL_REQ, .LOW_RATE_SELECT, .GRANT, .RECONFIG_BUSY, .TX_READY,
    .RX_READY, .LINK_READY, .CMD_START, .CMD_CHAN, .CMD_STREAM_MODE, .CMD_LOW_RATE,
    .IMAGE_VALID, .IMAGE_READY, .IMAGE_DATA, .DIGITAL_RESET, .DONE);

  reconfig_partner PARTNER (.clk(CLK), .cmd_start(CMD_START), .image_valid(IMAGE_VALID),
    .image_data(IMAGE_DATA), .digital_reset(DIGITAL_RESET), .stall, .hold, .slow,
    .image_ready(IMAGE_READY), .reconfig_busy(RECONFIG_BUSY), .tx_ready(TX_READY),
    .rx_ready(RX_READY), .link_ready(LINK_READY), .words, .last_word, .rst_len, .rst_mask);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk_vec

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : chk_bit

  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  // ****************************************
  // Requestors and stall source
  // ****************************************
  always @(posedge CLK) begin
    #1;
    seed = lfsr(seed);
    drive = (drive | want) & ~GRANT;
    want = '0;
    SPEED_DETECT_EN = m_en;
    DETECT_REQ = m_en ? drive : 4'h0;
    MANUAL_REQ = m_en ? 4'h0 : drive;
    DETECT_LOW_RATE = m_en ? rate : ~rate;
    LOW_RATE_SELECT = m_en ? ~rate : rate;
    stall = m_stall & seed[8];
    slow = m_stall;
    hold = m_hold;
  end

  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge CLK) begin
    #2;
    if (GRANT !== prev_grant && GRANT !== '0) begin
      chk_vec(16'(prev_grant), 16'h0, "grant overlap");
      cur = q.size() > 0 ? q.pop_front() : note_t'{7, 1'b0};
      chk_vec(16'(GRANT), 16'(1 << cur.chan), "grant");
    end
    if (CMD_START === 1'b1) chk_bit(CMD_STREAM_MODE, 1'b1, "stream mode");
    if (|DIGITAL_RESET) chk_bit(RECONFIG_BUSY, 1'b0, "reset while busy");
    if (DONE === 1'b1) begin
      chk_vec(16'(GRANT), 16'h0, "grant release");
      chk_vec(16'(CMD_CHAN), 16'(cur.chan), "channel");
      chk_bit(CMD_LOW_RATE, cur.rate, "rate");
      chk_vec(words, 16'(IMAGE_DEPTH), "image length");
      chk_vec(last_word, cur.rate ? E_LOW : E_HIGH, "image");
      chk_vec(rst_len, 16'(RST_PULSE_CYC), "reset width");
      chk_vec(16'(rst_mask), 16'(1 << cur.chan), "reset channel");
      jobs--;
    end
    prev_grant = GRANT;
  end

  task automatic run(input logic e, input logic s, input logic h, input logic [3:0] m);
    @(negedge CLK);
    m_en = e;
    m_stall = s;
    m_hold = h;
    rate = seed[12:9];
    for (int c = 0; c < 4; c++) begin
      if (m[c]) begin
        q.push_back('{c, rate[c]});
        jobs++;
      end
    end
    want = m;
    if (h) begin
      repeat (30) @(negedge CLK);
      chk_vec(16'({IMAGE_VALID, CMD_STREAM_MODE, CMD_START}), 16'h0, "start unready");
      m_hold = 1'b0;
    end
    for (int i = 0; i < 20000 && jobs > 0; i++) @(negedge CLK);
    chk_vec(16'(jobs), 16'h0, "jobs left unserviced");
  endtask : run

  initial begin
    repeat (10) @(posedge CLK);
    #1 RST = 1'b0;
    @(negedge CLK);
    chk_vec(16'({GRANT, DIGITAL_RESET, CMD_START, IMAGE_VALID, DONE}), 16'h0, "reset");
    run(1'b0, 1'b0, 1'b0, 4'hF);
    run(1'b1, 1'b1, 1'b0, 4'hF);
    run(1'b0, 1'b1, 1'b1, 4'h4);
    run(1'b1, 1'b0, 1'b0, 4'h9);
    results();
  end

  initial begin
    repeat (30000) @(posedge CLK);
    n_errors++;
    $display("ERROR %0t: run timed out", $time);
    results();
  end
endmodule : test_rate_switch_reconfig_sequencer
